// file: shared/itcq_pkg.sv
package itcq_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int APB_AW = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_FEAT = 12'h008;
    localparam logic [11:0] OFS_BASE_LO = 12'h080;
    localparam logic [11:0] OFS_BASE_HI = 12'h084;
    localparam logic [11:0] OFS_WOFS = 12'h088;
    localparam logic [11:0] OFS_ROFS = 12'h090;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EMPTY_BIT = 1;
    localparam int CTRL_FULL_BIT = 2;
    localparam int CTRL_QUIET_BIT = 31;
    localparam int FEAT_TFMT_BIT = 19;
    localparam int ROFS_HALT_BIT = 0;
    localparam int WOFS_RETRY_BIT = 0;

    localparam logic [63:0] BASE_RST = 64'h0000_0000_0000_0000;
    // valid, cacheability, address, shareability, page count
    localparam logic [63:0] BASE_WMASK = 64'hB80F_FFFF_FFFF_0CFF;
    localparam int BASE_VALID_BIT = 63;
    localparam int BASE_ADDR_MSB = 51;
    localparam int BASE_ADDR_LSB = 16;
    localparam int SIZE_W = 8;

    // ****************************************************************
    // queue geometry
    // ****************************************************************
    localparam int ADDR_W = 52;
    localparam int OFS_W = 20;
    localparam int SLOT_BYTES = 32;
    localparam int SLOT_SHIFT = 5;
    localparam int PAGE_SHIFT = 12;
    localparam int SLOTS_PER_PAGE = 1 << (PAGE_SHIFT - SLOT_SHIFT);
    localparam int DW_W = 64;
    localparam int DW_BYTES = 8;
    localparam int DWS = 4;
    localparam int CMD_W = DW_W * DWS;

    // ****************************************************************
    // command codes and argument limits
    // ****************************************************************
    localparam logic [7:0] OP_PEND_CLEAR = 8'h01;
    localparam logic [7:0] OP_PEND_SET = 8'h02;
    localparam logic [7:0] OP_UNMAP_DROP = 8'h03;
    localparam logic [7:0] OP_CACHE_REFRESH_EVENT = 8'h04;
    localparam logic [7:0] OP_CACHE_REFRESH_COLLECTION = 8'h05;
    localparam logic [7:0] OP_MAP_COLLECTION = 8'h06;
    localparam logic [7:0] OP_MAP_REQUESTER = 8'h07;
    localparam logic [7:0] OP_MAP_EVENT_IDENTITY = 8'h08;
    localparam logic [7:0] OP_MAP_EVENT_EXPLICIT = 8'h09;
    localparam logic [7:0] OP_MOVE_ALL_PENDING = 8'h0A;
    localparam logic [7:0] OP_MOVE_EVENT = 8'h0B;
    localparam logic [7:0] OP_BARRIER = 8'h0C;
    localparam logic [7:0] OP_CACHE_REFRESH_VCORE = 8'h10;
    localparam logic [7:0] OP_VMAP_EVENT_IDENTITY = 8'h11;
    localparam logic [7:0] OP_VMAP_CORE_TABLE = 8'h12;
    localparam logic [7:0] OP_VMAP_EVENT_EXPLICIT = 8'h13;
    localparam logic [7:0] OP_VMOVE_EVENT = 8'h14;
    localparam logic [7:0] OP_VMOVE_CORE = 8'h15;
    localparam logic [7:0] OP_VBARRIER = 8'h16;

    localparam logic [31:0] IRQ_MIN = 32'h0000_2000;
    localparam logic [31:0] DBELL_NONE = 32'h0000_03FF;

    typedef struct packed {
        logic [7:0] op;
        logic [31:0] requester;
        logic [31:0] event_num;
        logic [31:0] irq;
        logic [31:0] doorbell;
        logic [15:0] collection;
        logic [15:0] vcore;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] target2;
        logic [ADDR_W-1:0] addr;
        logic [4:0] size;
        logic barrier;
    } itcq_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_ISSUE = 4'b0100,
        ST_EXEC = 4'b1000
    } itcq_state_t;

endpackage

// file: verilog/itcq_decode.sv
`timescale 1ns/1ps

module itcq_decode (
    // fetched slot, double word 0 in the low bits
    input wire logic [itcq_pkg::CMD_W-1:0] raw,
    input wire logic tfmt,
    // decoded command
    output itcq_pkg::itcq_cmd_t cmd,
    output logic err
);

    logic [itcq_pkg::DW_W-1:0] dw0;
    logic [itcq_pkg::DW_W-1:0] dw1;
    logic [itcq_pkg::DW_W-1:0] dw2;
    logic [itcq_pkg::DW_W-1:0] dw3;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // address or processor number
    function automatic logic [itcq_pkg::ADDR_W-1:0] resolve_target(input logic [35:0] f, input logic sel);
        resolve_target = sel ? {f, 16'h0000} : {16'h0000, f};
    endfunction

    // doorbell must be none or a message irq
    function automatic logic bad_doorbell(input logic [31:0] d);
        bad_doorbell = (d != itcq_pkg::DBELL_NONE) && (d < itcq_pkg::IRQ_MIN);
    endfunction

    // lowest address double word sits lowest
    assign dw0 = raw[0 +: itcq_pkg::DW_W];
    assign dw1 = raw[itcq_pkg::DW_W +: itcq_pkg::DW_W];
    assign dw2 = raw[2 * itcq_pkg::DW_W +: itcq_pkg::DW_W];
    assign dw3 = raw[3 * itcq_pkg::DW_W +: itcq_pkg::DW_W];

    // ****************************************************************
    // field extraction
    // ****************************************************************
    always_comb
    begin
        cmd.op = dw0[7:0];
        cmd.requester = dw0[63:32];
        cmd.size = dw0[12:8];
        cmd.event_num = dw1[31:0];
        cmd.irq = dw1[63:32];
        cmd.addr = {dw1[51:8], 8'h00};
        cmd.collection = dw2[15:0];
        cmd.vcore = dw2[31:16];
        cmd.doorbell = dw2[63:32];
        cmd.target = resolve_target(dw3[51:16], tfmt);
        cmd.target2 = resolve_target(dw1[51:16], tfmt);
        cmd.barrier = 1'b0;
        err = 1'b0;
        case (dw0[7:0])
            itcq_pkg::OP_PEND_CLEAR,
            itcq_pkg::OP_PEND_SET,
            itcq_pkg::OP_UNMAP_DROP,
            itcq_pkg::OP_CACHE_REFRESH_EVENT,
            itcq_pkg::OP_CACHE_REFRESH_COLLECTION,
            itcq_pkg::OP_CACHE_REFRESH_VCORE,
            itcq_pkg::OP_MAP_COLLECTION,
            itcq_pkg::OP_MAP_REQUESTER,
            itcq_pkg::OP_MOVE_ALL_PENDING,
            itcq_pkg::OP_MOVE_EVENT,
            itcq_pkg::OP_VMOVE_EVENT,
            itcq_pkg::OP_VMAP_CORE_TABLE,
            itcq_pkg::OP_VMOVE_CORE:
            begin
                err = 1'b0;
            end
            itcq_pkg::OP_MAP_EVENT_IDENTITY:
            begin
                cmd.irq = dw1[31:0];
                err = dw1[31:0] < itcq_pkg::IRQ_MIN;
            end
            itcq_pkg::OP_MAP_EVENT_EXPLICIT:
            begin
                err = dw1[63:32] < itcq_pkg::IRQ_MIN;
            end
            itcq_pkg::OP_VMAP_EVENT_IDENTITY:
            begin
                cmd.irq = dw1[31:0];
                err = (dw1[31:0] < itcq_pkg::IRQ_MIN) || bad_doorbell(dw2[63:32]);
            end
            itcq_pkg::OP_VMAP_EVENT_EXPLICIT:
            begin
                err = (dw1[63:32] < itcq_pkg::IRQ_MIN) || bad_doorbell(dw2[63:32]);
            end
            itcq_pkg::OP_BARRIER,
            itcq_pkg::OP_VBARRIER:
            begin
                cmd.barrier = 1'b1;
            end
            default:
            begin
                err = 1'b1;
            end
        endcase
    end

endmodule

// file: verilog/itcq_top.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - each slot is 32 bytes, 128 per page
// - command words are little endian
// - base 64KB aligned, length whole pages
// - base register holds valid, attributes, address, size
// - read offset advances and wraps to base
// - equal offsets mean empty, nothing fetched
// - full when writer one slot behind
// - commands run strictly one after another
// - halt flag stops all command processing
// - each command atomic against translation requests
// - barrier completion orders later translations
// - barrier drains target outstanding work first
// - pending clear translates then clears pending
// - pending set translates then sets pending
// - unmap drop clears, refreshes, unmaps, drops
// - refresh caches per event, collection, core
// - bind collection to target, requester table
// - event map identity or explicit irq
// - move event pending state; move all
// - core table map and move set entry
// - retry bit resumes after halt on error
// - target is address or processor number

module itcq_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [itcq_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap, caught after reset
    input wire logic target_format_sel,
    // queue memory reads
    output logic mem_req,
    output logic [itcq_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [itcq_pkg::DW_W-1:0] mem_rdata,
    // command execution
    output logic exec_valid,
    output itcq_pkg::itcq_cmd_t exec_cmd,
    input wire logic exec_done,
    input wire logic exec_err,
    // translation path
    output logic xlate_hold
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    itcq_pkg::itcq_state_t state;
    itcq_pkg::itcq_state_t next_state;
    itcq_pkg::itcq_cmd_t dec_cmd;
    logic dec_err;
    logic ctrl_enable;
    logic [63:0] cbase;
    logic [itcq_pkg::OFS_W-1:0] wofs;
    logic [itcq_pkg::OFS_W-1:0] rofs;
    logic [itcq_pkg::OFS_W-1:0] q_end;
    logic [itcq_pkg::ADDR_W-1:0] base_addr;
    logic halted;
    logic tfmt;
    logic tfmt_taken;
    logic [1:0] dw_cnt;
    logic [itcq_pkg::DW_W-1:0] raw_dw [itcq_pkg::DWS];
    logic [itcq_pkg::CMD_W-1:0] raw;
    logic q_empty;
    logic q_full;
    logic can_run;
    logic quiet;
    logic wr_acc;
    logic ctrl_wr;
    logic base_lo_wr;
    logic base_hi_wr;
    logic wofs_wr;
    logic retry;
    logic [31:0] base_lo_new;
    logic [31:0] base_hi_new;
    logic [31:0] wofs_new;
    logic fetch_last;
    logic done_ok;
    logic halt_set;
    logic [31:0] rd_word;
    logic rd_ok;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // step one slot, wrap at the top
    function automatic logic [itcq_pkg::OFS_W-1:0] next_slot(
        input logic [itcq_pkg::OFS_W-1:0] ofs,
        input logic [itcq_pkg::OFS_W-1:0] qend
    );
        logic [itcq_pkg::OFS_W-1:0] s;
        s = ofs + itcq_pkg::OFS_W'(itcq_pkg::SLOT_BYTES);
        next_slot = (s >= qend) ? '0 : s;
    endfunction

    // byte lanes honoured on every register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                merge[8 * i +: 8] = nw[8 * i +: 8];
            end
        end
    endfunction

    // ****************************************************************
    // queue geometry and status
    // ****************************************************************
    // base on 64KB, length whole 4KB pages
    assign base_addr = {cbase[itcq_pkg::BASE_ADDR_MSB:itcq_pkg::BASE_ADDR_LSB], 16'h0000};
    assign q_end = {cbase[itcq_pkg::SIZE_W-1:0], {itcq_pkg::PAGE_SHIFT{1'b0}}};

    assign q_empty = wofs == rofs;
    assign q_full = next_slot(wofs, q_end) == rofs;

    assign can_run = ctrl_enable & cbase[itcq_pkg::BASE_VALID_BIT] & (|cbase[itcq_pkg::SIZE_W-1:0])
                     & ~halted & ~q_empty;
    assign quiet = (state == itcq_pkg::ST_IDLE) & (q_empty | ~ctrl_enable | halted);

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // zero wait states: data was latched during setup
    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite;
    assign ctrl_wr = wr_acc & (paddr == itcq_pkg::OFS_CTRL);
    assign base_lo_wr = wr_acc & (paddr == itcq_pkg::OFS_BASE_LO);
    assign base_hi_wr = wr_acc & (paddr == itcq_pkg::OFS_BASE_HI);
    assign wofs_wr = wr_acc & (paddr == itcq_pkg::OFS_WOFS);
    assign base_lo_new = merge(cbase[31:0], pwdata, pstrb) & itcq_pkg::BASE_WMASK[31:0];
    assign base_hi_new = merge(cbase[63:32], pwdata, pstrb) & itcq_pkg::BASE_WMASK[63:32];
    assign wofs_new = merge({12'h000, wofs}, pwdata, pstrb);
    assign retry = wofs_wr & pstrb[0] & pwdata[itcq_pkg::WOFS_RETRY_BIT];

    always_comb
    begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (paddr)
            itcq_pkg::OFS_CTRL:
            begin
                rd_word[itcq_pkg::CTRL_EN_BIT] = ctrl_enable;
                rd_word[itcq_pkg::CTRL_EMPTY_BIT] = q_empty;
                rd_word[itcq_pkg::CTRL_FULL_BIT] = q_full;
                rd_word[itcq_pkg::CTRL_QUIET_BIT] = quiet;
            end
            itcq_pkg::OFS_FEAT:
            begin
                rd_word[itcq_pkg::FEAT_TFMT_BIT] = tfmt;
            end
            itcq_pkg::OFS_BASE_LO:
            begin
                rd_word = cbase[31:0];
            end
            itcq_pkg::OFS_BASE_HI:
            begin
                rd_word = cbase[63:32];
            end
            itcq_pkg::OFS_WOFS:
            begin
                rd_word[itcq_pkg::OFS_W-1:0] = wofs;
            end
            itcq_pkg::OFS_ROFS:
            begin
                rd_word[itcq_pkg::OFS_W-1:0] = rofs;
                rd_word[itcq_pkg::ROFS_HALT_BIT] = halted;
            end
            default:
            begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= ~rd_ok;
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_enable <= 1'b0;
        end
        else if (ctrl_wr & pstrb[0])
        begin
            ctrl_enable <= pwdata[itcq_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cbase <= itcq_pkg::BASE_RST;
        end
        else if (base_lo_wr)
        begin
            cbase[31:0] <= base_lo_new;
        end
        else if (base_hi_wr)
        begin
            cbase[63:32] <= base_hi_new;
        end
    end

    // software sets the next free slot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wofs <= '0;
        end
        else if (wofs_wr)
        begin
            wofs <= {wofs_new[itcq_pkg::OFS_W-1:itcq_pkg::SLOT_SHIFT], {itcq_pkg::SLOT_SHIFT{1'b0}}};
        end
    end

    // strap is read once, after the reset has gone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tfmt <= 1'b0;
            tfmt_taken <= 1'b0;
        end
        else if (!tfmt_taken)
        begin
            tfmt <= target_format_sel;
            tfmt_taken <= 1'b1;
        end
    end

    // ****************************************************************
    // read offset and halt
    // ****************************************************************
    assign fetch_last = (state == itcq_pkg::ST_FETCH) & mem_ack & (dw_cnt == 2'd3);
    assign done_ok = (state == itcq_pkg::ST_EXEC) & exec_done & ~exec_err;
    assign halt_set = ((state == itcq_pkg::ST_ISSUE) & dec_err) | ((state == itcq_pkg::ST_EXEC) & exec_done & exec_err);

    // advance after each command that completes without error, wrap to base
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rofs <= '0;
        end
        else if (base_lo_wr | base_hi_wr)
        begin
            rofs <= '0;
        end
        else if (done_ok)
        begin
            rofs <= next_slot(rofs, q_end);
        end
    end

    // halt keeps the faulting slot, set wins over retry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halted <= 1'b0;
        end
        else if (halt_set)
        begin
            halted <= 1'b1;
        end
        else if (retry)
        begin
            halted <= 1'b0;
        end
    end

    // ****************************************************************
    // command sequencer
    // ****************************************************************
    // next fetch only from idle, after completion
    always_comb
    begin
        next_state = state;
        case (state)
            itcq_pkg::ST_IDLE:
            begin
                if (can_run)
                begin
                    next_state = itcq_pkg::ST_FETCH;
                end
            end
            itcq_pkg::ST_FETCH:
            begin
                if (fetch_last)
                begin
                    next_state = itcq_pkg::ST_ISSUE;
                end
            end
            itcq_pkg::ST_ISSUE:
            begin
                next_state = dec_err ? itcq_pkg::ST_IDLE : itcq_pkg::ST_EXEC;
            end
            itcq_pkg::ST_EXEC:
            begin
                if (exec_done)
                begin
                    next_state = itcq_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = itcq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= itcq_pkg::ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // slot fetch
    // ****************************************************************
    assign mem_req = state == itcq_pkg::ST_FETCH;

    // four double words make one 32-byte slot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dw_cnt <= 2'd0;
            mem_addr <= '0;
        end
        else if ((state == itcq_pkg::ST_IDLE) & can_run)
        begin
            dw_cnt <= 2'd0;
            mem_addr <= base_addr + {32'h0000_0000, rofs};
        end
        else if (mem_req & mem_ack)
        begin
            dw_cnt <= dw_cnt + 2'd1;
            mem_addr <= mem_addr + itcq_pkg::ADDR_W'(itcq_pkg::DW_BYTES);
        end
    end

    // each word lands by its address order
    for (genvar g = 0; g < itcq_pkg::DWS; g++)
    begin : g_dw
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                raw_dw[g] <= '0;
            end
            else if (mem_req & mem_ack & (dw_cnt == 2'(g)))
            begin
                raw_dw[g] <= mem_rdata;
            end
        end
        assign raw[g * itcq_pkg::DW_W +: itcq_pkg::DW_W] = raw_dw[g];
    end

    itcq_decode u_decode (
        .raw(raw),
        .tfmt(tfmt),
        .cmd(dec_cmd),
        .err(dec_err)
    );

    // ****************************************************************
    // execution
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exec_cmd <= '0;
        end
        else if ((state == itcq_pkg::ST_ISSUE) & ~dec_err)
        begin
            exec_cmd <= dec_cmd;
        end
    end

    assign exec_valid = state == itcq_pkg::ST_EXEC;
    // requests wait while a command applies
    assign xlate_hold = state == itcq_pkg::ST_EXEC;

endmodule

// file: verif/itcq_monitor.sv
`timescale 1ns/1ps

module itcq_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pslverr,
    // fetch and execute
    input wire logic mem_req,
    input wire logic [51:0] mem_addr,
    input wire logic mem_ack,
    input wire logic exec_valid,
    input wire itcq_pkg::itcq_cmd_t exec_cmd,
    input wire logic exec_done,
    input wire logic xlate_hold
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    hold_tracks_a: assert property (xlate_hold == exec_valid)
        else $error("hold not tied to exec");
    cmd_stable_a: assert property (exec_valid && !exec_done |=> $stable(exec_cmd))
        else $error("command moved in flight");
    fetch_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("fetch dropped early");
    dw_step_a: assert property (mem_req && mem_ack |=> mem_addr == $past(mem_addr) + 52'h8)
        else $error("fetch address step");
    one_cmd_a: assert property (exec_valid |-> !mem_req)
        else $error("fetch during exec");
    done_drop_a: assert property (exec_valid && exec_done |=> !exec_valid)
        else $error("exec held after done");
    idle_gap_a: assert property ($fell(exec_valid) |-> !mem_req)
        else $error("no idle gap");
    bad_addr_a: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
        else $error("unmapped not flagged");
endmodule

bind itcq_top itcq_monitor u_itcq_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_done(exec_done), .xlate_hold(xlate_hold));

// file: verif/itcq_mem_model.sv
`timescale 1ns/1ps

module itcq_mem_model (
    // clock
    input wire logic pclk,
    // queue memory
    input wire logic mem_req,
    input wire logic [51:0] mem_addr,
    output logic mem_ack,
    output logic [63:0] mem_rdata,
    // executor
    input wire logic exec_valid,
    input wire itcq_pkg::itcq_cmd_t exec_cmd,
    output logic exec_done,
    output logic exec_err
);
    logic [63:0] mem [int];
    logic [23:0] seen [$];
    logic [1:0] dly = 2'h0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 64'h0;
        exec_done = 1'b0;
        exec_err = 1'b0;
    end
    always @(posedge pclk)
    begin
        dly <= dly + 2'h1;
        if (mem_req && !mem_ack && dly != 2'h3)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[int'(mem_addr[33:3])];
        end
        else
        begin
            mem_ack <= 1'b0;
            // idle bus toggles, never holds data
            mem_rdata <= ~mem_rdata;
        end
        exec_done <= exec_valid && !exec_done && dly[0];
        // requester bit 0 asks the engine to report a failure
        exec_err <= exec_valid && !exec_done && dly[0] && exec_cmd.requester[0];
        if (exec_valid && !exec_done && dly[0])
            seen.push_back({exec_cmd.op, exec_cmd.collection});
    end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps

module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic tfs = 1'b1;
    logic [31:0] prdata, q;
    logic pready, pslverr, mem_req, mem_ack, exec_valid, exec_done, exec_err, xlate_hold, e;
    logic [51:0] mem_addr;
    logic [63:0] mem_rdata;
    itcq_pkg::itcq_cmd_t exec_cmd;
    logic [23:0] exp_q [$];
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h3c2f;
    initial forever #4 pclk = ~pclk;
    itcq_top u_itcq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .target_format_sel(tfs), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_done(exec_done),
        .exec_err(exec_err), .xlate_hold(xlate_hold));
    itcq_mem_model u_itcq_mem_model (.pclk(pclk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
        .exec_done(exec_done), .exec_err(exec_err));
    task summarize();
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // slot s of the queue at 0x10000, random collection
    task put(input int s, input logic [7:0] op);
        logic [15:0] c;
        int k;
        c = 16'($random(seed));
        k = 32'h0000_2000 + s * 4;
        u_itcq_mem_model.mem[k] = {56'h0, op};
        // irq at the floor, doorbell unused
        u_itcq_mem_model.mem[k + 1] = {32'h0000_2000, 32'h0000_2000};
        u_itcq_mem_model.mem[k + 2] = {32'h0000_03FF, 16'h0, c};
        u_itcq_mem_model.mem[k + 3] = 64'h0;
        exp_q.push_back({op, c});
    endtask
    function logic [7:0] opk(input int k);
        if (k % 19 < 12)
            return 8'(itcq_pkg::OP_PEND_CLEAR + k % 19);
        return 8'(itcq_pkg::OP_CACHE_REFRESH_VCORE + k % 19 - 12);
    endfunction
    task until_rofs(input logic [31:0] want);
        do apb(1'b0, itcq_pkg::OFS_ROFS, 32'h0); while (q !== want);
        while (exp_q.size() > 0)
            chk(u_itcq_mem_model.seen.pop_front(), exp_q.pop_front());
        chk(u_itcq_mem_model.seen.size(), 32'h0);
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail = n_fail + 1;
            summarize();
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, itcq_pkg::OFS_BASE_LO, 32'hFFFF_FFFF);
        apb(1'b0, itcq_pkg::OFS_BASE_LO, 32'h0);
        chk(q, itcq_pkg::BASE_WMASK[31:0]);
        apb(1'b1, itcq_pkg::OFS_BASE_LO, 32'h0001_0001);
        apb(1'b1, itcq_pkg::OFS_BASE_HI, 32'h8000_0000);
        apb(1'b0, itcq_pkg::OFS_FEAT, 32'h0);
        chk(q[itcq_pkg::FEAT_TFMT_BIT], 32'h1);
        apb(1'b0, 12'hFFC, 32'h0);
        chk(e, 32'h1);
        for (int k = 0; k < 100; k++)
            put(k, opk(k));
        apb(1'b1, itcq_pkg::OFS_WOFS, 32'h0000_0C80);
        apb(1'b1, itcq_pkg::OFS_CTRL, 32'h1);
        until_rofs(32'h0000_0C80);
        apb(1'b0, itcq_pkg::OFS_CTRL, 32'h0);
        chk(q, 32'h8000_0003);
        for (int k = 100; k < 130; k++)
            put(k % 128, opk(k));
        // disabled so the full queue is only looked at, never run
        apb(1'b1, itcq_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, itcq_pkg::OFS_WOFS, 32'h0000_0C60);
        apb(1'b0, itcq_pkg::OFS_CTRL, 32'h0);
        chk(q, 32'h8000_0004);
        apb(1'b1, itcq_pkg::OFS_WOFS, 32'h0000_0040);
        apb(1'b1, itcq_pkg::OFS_CTRL, 32'h1);
        until_rofs(32'h0000_0040);
        put(2, 8'hFF);
        exp_q.delete();
        apb(1'b1, itcq_pkg::OFS_WOFS, 32'h0000_0060);
        until_rofs(32'h0000_0041);
        put(2, opk(5));
        apb(1'b1, itcq_pkg::OFS_WOFS, 32'h0000_0061);
        until_rofs(32'h0000_0060);
        put(3, opk(6));
        u_itcq_mem_model.mem[32'h0000_200C][32] = 1'b1;
        apb(1'b1, itcq_pkg::OFS_WOFS, 32'h0000_0080);
        until_rofs(32'h0000_0061);
        // second reset with the strap low
        tfs <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, itcq_pkg::OFS_ROFS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, itcq_pkg::OFS_FEAT, 32'h0);
        chk(q[itcq_pkg::FEAT_TFMT_BIT], 32'h0);
        summarize();
    end
endmodule
